// ==== rtl/cbr_reg_cell.sv ====
// Purpose: One 16-bit config register with a writable-bit mask
// Assumes: Write strobe is a single-cycle APB access-phase pulse
// Notes: Masked-out bits are constant zero
`timescale 1ns/1ns
module cbr_reg_cell #(
    parameter logic [15:0] RST = 16'h0000,
    parameter logic [15:0] WMASK = 16'hFFFF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr,
    input wire logic [15:0] wdata,
    output logic [15:0] q
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [15:0] q_d;
    logic [15:0] reg_q;

    // Read-only bits never hold state, so they read zero
    // hold and zero
    assign q_d = wr ? (wdata & WMASK) : reg_q;
    assign q = reg_q;

    // Register process
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_q <= RST & WMASK;
        end else begin
            reg_q <= q_d;
        end
    end

endmodule

// ==== rtl/cbr_regs.sv ====
// Purpose: APB register bank for clock buffer output configuration
// Assumes: 32-bit APB, registers in low 16 bits, byte address = index * 4
// Notes: Zero-wait-state slave; unmapped addresses read zero and raise pslverr
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "cbr_params.svh"
module cbr_regs
    import cbr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output cbr_cfg_t cfg
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Index 0x5A needs 9 byte-address bits
    if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr
        $error("cbr_regs: ADDR_W must be 9..32");
    end

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    localparam int NREG = 8;
    wire logic [6:0] idx;
    wire logic aligned;
    wire logic upper_zero;
    wire logic setup;
    wire logic access;
    wire logic [NREG-1:0] hit;
    wire logic mapped;
    wire logic wr_ok;
    wire logic [NREG-1:0] wr_sel;

    // Decode one index against the access word address
    function automatic logic idx_hit(input logic [6:0] a, input logic [6:0] r);
        idx_hit = (a == r);
    endfunction

    assign idx = paddr[8:2];
    assign aligned = (paddr[1:0] == 2'h0);
    // Bits above the map must be zero, else unmapped
    assign upper_zero = (ADDR_W > 9) ? ((paddr >> 9) == '0) : 1'b1;
    assign setup = psel && !penable;
    assign access = psel && penable;

    assign hit[0] = idx_hit(idx, `CBR_IDX_FSM_CLK);
    assign hit[1] = idx_hit(idx, `CBR_IDX_MAIN_EN);
    assign hit[2] = idx_hit(idx, `CBR_IDX_PWR_LO);
    assign hit[3] = idx_hit(idx, `CBR_IDX_PWR_HI);
    assign hit[4] = idx_hit(idx, `CBR_IDX_AUX_LVL);
    assign hit[5] = idx_hit(idx, `CBR_IDX_AUX_DIV);
    assign hit[6] = idx_hit(idx, `CBR_IDX_COMP_A);
    assign hit[7] = idx_hit(idx, `CBR_IDX_COMP_B);
    assign mapped = (|hit) && aligned && upper_zero;

    // A write lands only with both low byte lanes enabled, keeping 16-bit fields whole
    assign wr_ok = access && pwrite && mapped && (pstrb[1:0] == 2'h3);
    assign wr_sel = wr_ok ? hit : '0;

    // ----------------------------------------
    // Register cells
    // ----------------------------------------
    logic [15:0] r_fsm_clk;
    logic [15:0] r_main_en;
    logic [15:0] r_pwr_lo;
    logic [15:0] r_pwr_hi;
    logic [15:0] r_aux_lvl;
    logic [15:0] r_aux_div;
    logic [15:0] r_comp_a;
    logic [15:0] r_comp_b;

    cbr_reg_cell #(.RST(`CBR_RST_FSM_CLK), .WMASK(`CBR_WM_FSM_CLK)) u_fsm_clk (
        .pclk(pclk), .presetn(presetn), .wr(wr_sel[0]), .wdata(pwdata[15:0]), .q(r_fsm_clk));
    cbr_reg_cell #(.RST(`CBR_RST_MAIN_EN), .WMASK(`CBR_WM_MAIN_EN)) u_main_en (
        .pclk(pclk), .presetn(presetn), .wr(wr_sel[1]), .wdata(pwdata[15:0]), .q(r_main_en));
    cbr_reg_cell #(.RST(`CBR_RST_PWR_LO), .WMASK(`CBR_WM_PWR_LO)) u_pwr_lo (
        .pclk(pclk), .presetn(presetn), .wr(wr_sel[2]), .wdata(pwdata[15:0]), .q(r_pwr_lo));
    cbr_reg_cell #(.RST(`CBR_RST_PWR_HI), .WMASK(`CBR_WM_PWR_HI)) u_pwr_hi (
        .pclk(pclk), .presetn(presetn), .wr(wr_sel[3]), .wdata(pwdata[15:0]), .q(r_pwr_hi));
    cbr_reg_cell #(.RST(`CBR_RST_AUX_LVL), .WMASK(`CBR_WM_AUX_LVL)) u_aux_lvl (
        .pclk(pclk), .presetn(presetn), .wr(wr_sel[4]), .wdata(pwdata[15:0]), .q(r_aux_lvl));
    cbr_reg_cell #(.RST(`CBR_RST_AUX_DIV), .WMASK(`CBR_WM_AUX_DIV)) u_aux_div (
        .pclk(pclk), .presetn(presetn), .wr(wr_sel[5]), .wdata(pwdata[15:0]), .q(r_aux_div));
    // Companion register, stored as written
    cbr_reg_cell #(.RST(`CBR_RST_COMP_A), .WMASK(`CBR_WM_COMP)) u_comp_a (
        .pclk(pclk), .presetn(presetn), .wr(wr_sel[6]), .wdata(pwdata[15:0]), .q(r_comp_a));
    cbr_reg_cell #(.RST(`CBR_RST_COMP_B), .WMASK(`CBR_WM_COMP)) u_comp_b (
        .pclk(pclk), .presetn(presetn), .wr(wr_sel[7]), .wdata(pwdata[15:0]), .q(r_comp_b));

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire logic [15:0] rd_mux;
    assign rd_mux = ({16{hit[0]}} & r_fsm_clk) | ({16{hit[1]}} & r_main_en)
                  | ({16{hit[2]}} & r_pwr_lo) | ({16{hit[3]}} & r_pwr_hi)
                  | ({16{hit[4]}} & r_aux_lvl) | ({16{hit[5]}} & r_aux_div)
                  | ({16{hit[6]}} & r_comp_a) | ({16{hit[7]}} & r_comp_b);

    // ----------------------------------------
    // Decoded configuration
    // ----------------------------------------
    cbr_cfg_t cfg_d;
    cbr_cfg_t cfg_q;
    wire logic [2:0] prediv;
    wire cbr_fmt_t fmt;
    assign prediv = r_aux_div[`CBR_PREDIV_LSB +: 3];
    assign fmt = cbr_fmt_t'(r_aux_div[`CBR_FMT_LSB +: 2]);

    always_comb begin
        cfg_d = '0;
        // state-machine clock enable
        // Pin modes stop when software clears this after init
        cfg_d.fsm_clock_gen_enable = r_fsm_clk[`CBR_FSM_CLK_BIT];
        cfg_d.main_out_enable = r_main_en[`CBR_MAIN_EN_LSB +: 4];
        cfg_d.main_out1_power = r_pwr_lo[`CBR_PWR1_LSB +: 3];
        cfg_d.main_out0_power = r_pwr_lo[`CBR_PWR0_LSB +: 3];
        cfg_d.main_out3_power = r_pwr_hi[`CBR_PWR3_LSB +: 3];
        cfg_d.main_out2_power = r_pwr_hi[`CBR_PWR2_LSB +: 3];
        cfg_d.aux_common_mode_sel = r_aux_lvl[`CBR_VCM_LSB +: 2];
        cfg_d.lvds_vcm_active = (fmt == CBR_FMT_LVDS);
        cfg_d.aux_predriver_power = r_aux_lvl[`CBR_PREDRV_LSB +: 2];
        cfg_d.aux_driver_power = r_aux_lvl[`CBR_DRVPWR_LSB +: 3];
        cfg_d.cml_power_active = (fmt == CBR_FMT_CML);
        // only 1, 2, 4 legal
        // Reserved codes are stored but flagged, never silently altered
        cfg_d.aux_predivide_ratio = prediv;
        cfg_d.aux_predivide_legal = (prediv == 3'h1) || (prediv == 3'h2) || (prediv == 3'h4);
        cfg_d.aux_subsystem_enable = r_aux_div[`CBR_AUXEN_BIT];
        cfg_d.aux_driver_format = fmt;
        cfg_d.aux_bypass_second = r_comp_b[`CBR_BYP2_BIT];
        cfg_d.aux_bypass_third = r_comp_b[`CBR_BYP3_BIT];
    end

    // ----------------------------------------
    // Output flops
    // ----------------------------------------
    // Config output is registered, so it lags register contents by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end
    assign cfg = cfg_q;

    // APB answer: registered during setup, valid in the access phase
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            // Answer comes one cycle after setup, then drops
            pready_q <= setup;
            pslverr_q <= setup && !mapped;
            prdata_q <= (setup && !pwrite && mapped) ? {16'h0000, rd_mux} : 32'h0000_0000;
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

endmodule

// ==== shared/cbr_params.svh ====
// Purpose: Offsets, field positions, reset values for the clock buffer config bank
// Assumes: APB byte address is four times the register index
// Notes: Field positions are bit indices inside the 16-bit register word
//
// How it works
// - Offset 0x2 bit 5 enables FSM clock
// - Offset 0x3 bits 15-12 enable main outputs
// - Offset 0x4 holds output 1/0 power
// - Offset 0x5 holds output 3/2 power
// - Offset 0x7 common mode, LVDS only
// - Offset 0x7 pre-driver power level
// - Offset 0x7 driver power, CML only
// - Offset 0x8 pre-divide ratio 1/2/4
// - Offset 0x8 format and subsystem enable
// - Offset 0x5A holds two bypass bits
`ifndef CBR_PARAMS_SVH
`define CBR_PARAMS_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define CBR_IDX_FSM_CLK 7'h02
`define CBR_IDX_MAIN_EN 7'h03
`define CBR_IDX_PWR_LO 7'h04
`define CBR_IDX_PWR_HI 7'h05
`define CBR_IDX_AUX_LVL 7'h07
`define CBR_IDX_AUX_DIV 7'h08
`define CBR_IDX_COMP_A 7'h4F
`define CBR_IDX_COMP_B 7'h5A

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CBR_RST_FSM_CLK 16'h0223
`define CBR_RST_MAIN_EN 16'hF0FE
`define CBR_RST_PWR_LO 16'h36FF
`define CBR_RST_PWR_HI 16'h36F6
`define CBR_RST_AUX_LVL 16'h543F
`define CBR_RST_AUX_DIV 16'h0120
`define CBR_RST_COMP_A 16'h0000
`define CBR_RST_COMP_B 16'h0000

// ----------------------------------------
// Writable bit masks (read-only bits clear)
// ----------------------------------------
`define CBR_WM_FSM_CLK 16'h07FF
`define CBR_WM_MAIN_EN 16'hFFFF
`define CBR_WM_PWR_LO 16'h3FFF
`define CBR_WM_PWR_HI 16'h7FFF
`define CBR_WM_AUX_LVL 16'h7FFF
`define CBR_WM_AUX_DIV 16'h01FF
`define CBR_WM_COMP 16'hFFFF

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CBR_FSM_CLK_BIT 5
`define CBR_MAIN_EN_LSB 12
`define CBR_PWR0_LSB 8
`define CBR_PWR1_LSB 11
`define CBR_PWR2_LSB 0
`define CBR_PWR3_LSB 3
`define CBR_VCM_LSB 11
`define CBR_PREDRV_LSB 7
`define CBR_DRVPWR_LSB 1
`define CBR_PREDIV_LSB 6
`define CBR_AUXEN_BIT 5
`define CBR_FMT_LSB 0
`define CBR_BYP2_BIT 5
`define CBR_BYP3_BIT 6

`endif

// ==== shared/cbr_pkg.sv ====
// Purpose: Types for the clock buffer config bank
// Assumes: Constants come from cbr_params.svh
// Notes: Types only
package cbr_pkg;

    // Driver format codes
    typedef enum logic [1:0] {
        CBR_FMT_LVDS = 2'h0,
        CBR_FMT_RSV1 = 2'h1,
        CBR_FMT_CML = 2'h2,
        CBR_FMT_RSV3 = 2'h3
    } cbr_fmt_t;

    // Decoded configuration handed to the analog side
    typedef struct packed {
        logic fsm_clock_gen_enable;
        logic [3:0] main_out_enable;
        logic [2:0] main_out0_power;
        logic [2:0] main_out1_power;
        logic [2:0] main_out2_power;
        logic [2:0] main_out3_power;
        logic [1:0] aux_common_mode_sel;
        logic lvds_vcm_active;
        logic [1:0] aux_predriver_power;
        logic [2:0] aux_driver_power;
        logic cml_power_active;
        logic [2:0] aux_predivide_ratio;
        logic aux_predivide_legal;
        logic aux_subsystem_enable;
        cbr_fmt_t aux_driver_format;
        logic aux_bypass_second;
        logic aux_bypass_third;
    } cbr_cfg_t;

endpackage

// ==== testbench/cbr_regs_checker.sv ====
// Purpose: Port-level checks of the config register bank
// Assumes: Zero-wait APB slave, cfg one edge behind the register
// Notes: Bound from the bench top file
`timescale 1ns/1ns
module cbr_regs_checker
    import cbr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire cbr_cfg_t cfg
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Accepted full write in this cycle
    wire wr_ok = pready && pwrite && !pslverr && pstrb[1:0] == 2'h3;
    logic [15:0] wd_q; // Last accepted word, held for cfg checks
    // Capture the word, cfg follows two edges later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_q <= 16'h0000;
        end else if (wr_ok) begin
            wd_q <= pwdata[15:0];
        end
    end
    chk_ready_setup: assert property (psel && !penable |=> pready && penable)
        else $error("no ready after setup");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    chk_err_unaligned: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
        else $error("unaligned access not refused");
    chk_upper_zero: assert property (prdata[31:16] == 16'h0)
        else $error("upper read half not zero");
    chk_fsm_enable: assert property (wr_ok && paddr == 12'h008 |=> ##1 cfg.fsm_clock_gen_enable == wd_q[5])
        else $error("fsm clock enable wrong");
    chk_main_enable: assert property (wr_ok && paddr == 12'h00C |=> ##1 cfg.main_out_enable == wd_q[15:12])
        else $error("main enables wrong");
    chk_power_low: assert property (wr_ok && paddr == 12'h010 |=> ##1
        {cfg.main_out1_power, cfg.main_out0_power} == wd_q[13:8])
        else $error("low pair power wrong");
    chk_power_high: assert property (wr_ok && paddr == 12'h014 |=> ##1
        {cfg.main_out3_power, cfg.main_out2_power} == wd_q[5:0])
        else $error("high pair power wrong");
    chk_aux_level: assert property (wr_ok && paddr == 12'h01C |=> ##1 {cfg.aux_common_mode_sel,
        cfg.aux_predriver_power, cfg.aux_driver_power} == {wd_q[12:11], wd_q[8:7], wd_q[3:1]})
        else $error("aux level fields wrong");
    chk_aux_divide: assert property (wr_ok && paddr == 12'h020 |=> ##1 {cfg.aux_predivide_ratio,
        cfg.aux_subsystem_enable, cfg.aux_driver_format} == {wd_q[8:5], wd_q[1:0]})
        else $error("aux divide fields wrong");
    chk_legal_flag: assert property (cfg.aux_predivide_legal == (cfg.aux_predivide_ratio inside {3'h1, 3'h2, 3'h4}))
        else $error("predivide legal flag wrong");
    chk_bypass_bits: assert property (wr_ok && paddr == 12'h168 |=> ##1
        {cfg.aux_bypass_third, cfg.aux_bypass_second} == wd_q[6:5])
        else $error("bypass bits wrong");
endmodule

// ==== testbench/cbr_regs_tb.sv ====
// Purpose: Self-checking bench for the config register bank
// Assumes: Zero-wait APB slave, cfg two edges after a write
// Notes: At least one idle cycle between transfers, three after wr
`timescale 1ns/1ns
module cbr_regs_tb
    import cbr_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    cbr_cfg_t cfg;
    int n_mismatch, checked, i;
    // Bank map, reset words and writable masks
    logic [11:0] ad [8] = '{12'h008, 12'h00C, 12'h010, 12'h014, 12'h01C, 12'h020, 12'h13C, 12'h168};
    logic [15:0] rv [8] = '{16'h0223, 16'hF0FE, 16'h36FF, 16'h36F6, 16'h543F, 16'h0120, 16'h0000, 16'h0000};
    logic [15:0] wm [8] = '{16'h07FF, 16'hFFFF, 16'h3FFF, 16'h7FFF, 16'h7FFF, 16'h01FF, 16'hFFFF, 16'hFFFF};
    cbr_regs cbr_regs_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg)
    );
    // ----------------------------------------
    // Bus tasks and compare
    // ----------------------------------------
    task finish_test();
        if (n_mismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Setup, access, bounded wait for ready
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // Look mid-cycle, where the registered answer has settled
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            $display("Error at %0t: no ready", $time);
            n_mismatch++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        // Request stands through the edge that samples ready
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Write, then let cfg settle
    task wr(input logic [11:0] a, input logic [15:0] d);
        xfer(1'b1, a, {16'h0, d}, 4'hF);
        repeat (2) @(posedge pclk);
    endtask
    task rdc(input logic [11:0] a, input logic [15:0] e);
        xfer(1'b0, a, 32'h0, 4'h0);
        chk(rd, {16'h0, e});
        chk({31'h0, er}, 32'h0);
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        n_mismatch = 0;
        checked = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(32'({cfg.fsm_clock_gen_enable, cfg.main_out_enable, cfg.aux_predivide_ratio}), 32'h0FC);
        chk(32'({cfg.main_out0_power, cfg.main_out1_power, cfg.main_out2_power, cfg.main_out3_power}), 32'hDB6);
        chk(32'({cfg.aux_common_mode_sel, cfg.aux_predriver_power, cfg.aux_driver_power, cfg.aux_subsystem_enable,
            cfg.aux_driver_format, cfg.lvds_vcm_active, cfg.aux_predivide_legal}), 32'h8F3);
        // Reset words, then read-only bits ignore ones
        for (i = 0; i < 8; i++) begin
            rdc(ad[i], rv[i]);
            xfer(1'b1, ad[i], {16'hFFFF, rv[i] | ~wm[i]}, 4'hF);
            rdc(ad[i], rv[i]);
        end
        // Partial strobe and unmapped places refused
        xfer(1'b1, 12'h00C, 32'h0, 4'hC);
        rdc(12'h00C, 16'hF0FE);
        xfer(1'b0, 12'h004, 32'h0, 4'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        xfer(1'b0, 12'h009, 32'h0, 4'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        wr(12'h008, 16'h0203);
        chk(32'(cfg.fsm_clock_gen_enable), 32'h0);
        wr(12'h00C, 16'h50FE);
        chk(32'(cfg.main_out_enable), 32'h5);
        wr(12'h010, 16'h1DFF);
        wr(12'h014, 16'h36CF);
        chk(32'({cfg.main_out0_power, cfg.main_out1_power, cfg.main_out2_power, cfg.main_out3_power}), 32'hAF9);
        wr(12'h01C, 16'h4DBB);
        chk(32'({cfg.aux_common_mode_sel, cfg.aux_predriver_power, cfg.aux_driver_power}), 32'h3D);
        // Every format code with its decode flags
        for (i = 0; i < 4; i++) begin
            wr(12'h020, 16'h0120 | 16'(i));
            chk(32'({cfg.aux_driver_format, cfg.lvds_vcm_active, cfg.cml_power_active}),
                32'(i * 4 + 2 * (i == 0) + (i == 2)));
        end
        // Every predivide code, subsystem off
        for (i = 0; i < 8; i++) begin
            wr(12'h020, 16'(i << 6));
            chk(32'({cfg.aux_predivide_ratio, cfg.aux_predivide_legal, cfg.aux_subsystem_enable}),
                32'(i * 4 + 2 * (i inside {1, 2, 4})));
        end
        // Divide by one with both companion words
        wr(12'h020, 16'h0060);
        wr(12'h13C, 16'h0005);
        wr(12'h168, 16'h0060);
        chk(32'({cfg.aux_bypass_third, cfg.aux_bypass_second}), 32'h3);
        rdc(12'h13C, 16'h0005);
        // Reset in mid-run restores the bank
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'h168, 16'h0000);
        rdc(12'h008, 16'h0223);
        finish_test();
    end
endmodule
bind cbr_regs cbr_regs_checker #(.ADDR_W(ADDR_W)) cbr_regs_checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg)
);
